// [core/i2rt_target.v]
/*
 * I2C target port with auto-incrementing register pointer.
 * Assumes external pull-ups, a register file outside, and a strap
 * sense result that is stable once bias_power_good rises.
 */
`default_nettype none
`include "i2rt_defs.vh"

module i2rt_target (
    // Clock and reset
    input  wire       core_clk_i,
    input  wire       rst_b_i,
    // Bus pins (open drain)
    input  wire       scl_i,
    input  wire       sda_i,
    output wire       sda_o,
    output wire       sda_oe_o,
    // Sequencer and strap
    input  wire       bias_power_good_i,
    input  wire [2:0] strap_code_i,
    // Strap results
    output reg  [6:0] bus_addr_o,
    output reg  [1:0] clock_role_o,
    output reg        sync_fall_o,
    // Register file side
    output reg  [7:0] reg_ptr_o,
    output reg  [7:0] wr_data_o,
    output reg        wr_strobe_o,
    input  wire [7:0] rd_data_i
);

    // =========================================================
    // States
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_REGA = 3'h2;
    localparam ST_WDAT = 3'h3;
    localparam ST_RDAT = 3'h4;
    localparam ST_RACK = 3'h5;

    // Address decode from the strap code; role is decoded from the strap code separately
    function [6:0] strap_addr;
        input [2:0] code;
        begin
            case (code)
                `I2RT_STRAP_GND:  strap_addr = `I2RT_ADDR_GND;
                `I2RT_STRAP_R20K: strap_addr = `I2RT_ADDR_R20K;
                `I2RT_STRAP_R30K: strap_addr = `I2RT_ADDR_R30K;
                `I2RT_STRAP_R40K: strap_addr = `I2RT_ADDR_R40K;
                `I2RT_STRAP_R50K: strap_addr = `I2RT_ADDR_R50K;
                default:          strap_addr = `I2RT_ADDR_OPEN;
            endcase
        end
    endfunction

    // =========================================================
    // Input synchronisation
    // Power good must reset low, or the port would wake for two cycles
    wire [5:0] pin_s;
    i2rt_sync2 #(
        .WIDTH   (6),
        .RST_VAL (`I2RT_SYNC_RST)
    ) u_sync (
        .clk_i   (core_clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({strap_code_i, bias_power_good_i, scl_i, sda_i}),
        .q_o     (pin_s)
    );
    wire [2:0] strap_s = pin_s[5:3];
    wire pg_s  = pin_s[2];
    wire scl_s = pin_s[1];
    wire sda_s = pin_s[0];

    reg scl_q;
    reg sda_q;
    reg pg_q;
    reg [2:0] state_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg [7:0] tx_q;
    reg       drive_low_q;
    reg       rw_q;

    // Edge and condition detection
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
    wire active   = pg_s;

    // =========================================================
    // Strap latch at power-good rise; a clocked capture, not reset
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pg_q         <= 1'b0;
            bus_addr_o   <= `I2RT_ADDR_OPEN;
            clock_role_o <= `I2RT_ROLE_ALONE;
            sync_fall_o  <= 1'b0;
        end else begin
            pg_q <= pg_s;
            if (pg_s && !pg_q) begin
                bus_addr_o <= strap_addr(strap_s);
                // Role follows the strap
                if (strap_s == `I2RT_STRAP_GND)
                    clock_role_o <= `I2RT_ROLE_ALONE;
                else if (strap_s >= `I2RT_STRAP_OPEN)
                    clock_role_o <= `I2RT_ROLE_MASTER;
                else
                    clock_role_o <= `I2RT_ROLE_SLAVE;
                sync_fall_o <= (strap_s == `I2RT_STRAP_R30K) ||
                               (strap_s == `I2RT_STRAP_R50K);
            end
        end
    end

    // =========================================================
    // Protocol engine
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_q       <= 1'b1;
            sda_q       <= 1'b1;
            state_q     <= ST_IDLE;
            bit_q       <= 4'h0;
            shift_q     <= 8'h00;
            tx_q        <= 8'h00;
            drive_low_q <= 1'b0;
            rw_q        <= 1'b0;
            reg_ptr_o   <= `I2RT_PTR_RESET;
            wr_data_o   <= 8'h00;
            wr_strobe_o <= 1'b0;
        end else begin
            scl_q       <= scl_s;
            sda_q       <= sda_s;
            wr_strobe_o <= 1'b0;
            if (!active) begin
                state_q     <= ST_IDLE;
                drive_low_q <= 1'b0;
            end else if (start_c) begin
                // Repeated START also lands here
                state_q     <= ST_ADDR;
                bit_q       <= 4'h0;
                drive_low_q <= 1'b0;
            end else if (stop_c) begin
                state_q     <= ST_IDLE;  // pointer kept
                drive_low_q <= 1'b0;
            end else if (scl_rise) begin
                if (state_q == ST_RDAT || state_q == ST_RACK) begin
                    // Pointer bumps on the fifth clock
                    if (state_q == ST_RDAT && bit_q == `I2RT_READ_INC_BIT - 4'h1)
                        reg_ptr_o <= reg_ptr_o + 8'h01;
                    if (state_q == ST_RACK && sda_s)
                        state_q <= ST_IDLE;  // host NACK ends the read
                end else if (state_q != ST_IDLE && bit_q < `I2RT_ACK_BIT) begin
                    shift_q <= {shift_q[6:0], sda_s};
                end
                bit_q <= bit_q + 4'h1;
            end else if (scl_fall) begin
                case (state_q)
                    ST_ADDR, ST_REGA, ST_WDAT: begin
                        if (bit_q == `I2RT_ACK_BIT) begin
                            if (state_q == ST_ADDR) begin
                                if (shift_q[7:1] == bus_addr_o) begin
                                    drive_low_q <= 1'b1;
                                    rw_q        <= shift_q[0];
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end else begin
                                drive_low_q <= 1'b1;
                            end
                        end else if (bit_q == `I2RT_ACK_BIT + 4'h1) begin
                            drive_low_q <= 1'b0;
                            bit_q       <= 4'h0;
                            case (state_q)
                                ST_ADDR: begin
                                    if (rw_q) begin
                                        // Byte picked at its start
                                        state_q     <= ST_RDAT;
                                        tx_q        <= {rd_data_i[6:0], 1'b0};
                                        drive_low_q <= ~rd_data_i[7];
                                    end else begin
                                        state_q <= ST_REGA;
                                    end
                                end
                                ST_REGA: begin
                                    reg_ptr_o <= shift_q;
                                    state_q   <= ST_WDAT;
                                end
                                default: begin
                                    wr_data_o   <= shift_q;
                                    wr_strobe_o <= 1'b1;
                                    reg_ptr_o   <= reg_ptr_o + 8'h01;
                                end
                            endcase
                        end
                    end
                    ST_RDAT: begin
                        if (bit_q == `I2RT_ACK_BIT) begin
                            drive_low_q <= 1'b0;  // release for host ACK
                            state_q     <= ST_RACK;
                        end else begin
                            drive_low_q <= ~tx_q[7];
                            tx_q        <= {tx_q[6:0], 1'b0};
                        end
                    end
                    ST_RACK: begin
                        // Host ACKed: next byte from current pointer
                        bit_q       <= 4'h0;
                        state_q     <= ST_RDAT;
                        tx_q        <= {rd_data_i[6:0], 1'b0};
                        drive_low_q <= ~rd_data_i[7];
                    end
                    default: drive_low_q <= 1'b0;
                endcase
            end
        end
    end

    // Open drain: output always low, enable only pulls
    assign sda_o    = 1'b0;
    assign sda_oe_o = drive_low_q;

endmodule // i2rt_target
`default_nettype wire

// [core/i2rt_defs.vh]
/*
 * Constants for the I2C target register-access port.
 * Assumes inclusion by the core files only; definitions only.
 */
`ifndef I2RT_DEFS_VH
`define I2RT_DEFS_VH

// =============================================================
// Strap codes (3-bit sense result) and bus addresses
`define I2RT_STRAP_GND      3'h0
`define I2RT_STRAP_R20K     3'h1
`define I2RT_STRAP_R30K     3'h2
`define I2RT_STRAP_R40K     3'h3
`define I2RT_STRAP_R50K     3'h4
`define I2RT_STRAP_OPEN     3'h5
`define I2RT_ADDR_GND       7'h08
`define I2RT_ADDR_R20K      7'h09
`define I2RT_ADDR_R30K      7'h0a
`define I2RT_ADDR_R40K      7'h0b
`define I2RT_ADDR_R50K      7'h0c
`define I2RT_ADDR_OPEN      7'h0d

// =============================================================
// Clock roles
`define I2RT_ROLE_ALONE     2'h0
`define I2RT_ROLE_SLAVE     2'h1
`define I2RT_ROLE_MASTER    2'h2

// =============================================================
// Pointer and bit counts
`define I2RT_PTR_RESET      8'h00
`define I2RT_READ_INC_BIT   4'h5
`define I2RT_ACK_BIT        4'h8

// =============================================================
// Synchroniser reset: strap and power good low, bus lines idle high
`define I2RT_SYNC_RST       6'h03

`endif

// [core/i2rt_sync2.v]
/*
 * Two-flop synchroniser, parameterised width.
 * Assumes the inputs are asynchronous to clk_i.
 */
`default_nettype none

module i2rt_sync2 #(
    parameter             WIDTH   = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_b_i,
    // Data
    input  wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);

    // =========================================================
    // Stages
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage read only by the second; reset to each line's idle level
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule // i2rt_sync2
`default_nettype wire

// [testbench/i2rt_target_chk.sv]
/*
 * Port checker for the I2C target.
 * Assumes it is bound to i2rt_target and sees only its ports.
 */
`default_nettype none

module i2rt_target_chk (
    // Clock and reset
    input wire logic       core_clk_i,
    input wire logic       rst_b_i,
    // Bus and strap
    input wire logic       scl_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       bias_power_good_i,
    input wire logic [2:0] strap_code_i,
    // Results
    input wire logic [6:0] bus_addr_o,
    input wire logic [1:0] clock_role_o,
    input wire logic       sync_fall_o,
    input wire logic [7:0] reg_ptr_o,
    input wire logic       wr_strobe_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // =========================================================
    // Properties
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sda_low_only_a: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("sda driven high");
    idle_no_pg_a: assert property (!bias_power_good_i [*5] |-> !sda_oe_o)
        else $error("bus used without power good");
    ptr_idle_a: assert property (!bias_power_good_i [*5] |-> $stable(reg_ptr_o))
        else $error("pointer moved without power good");
    strobe_inc_a: assert property (wr_strobe_o |-> reg_ptr_o == $past(reg_ptr_o) + 8'h01)
        else $error("no pointer step at write");
    strobe_pulse_a: assert property (wr_strobe_o |=> !wr_strobe_o)
        else $error("write strobe too long");
    addr_strap_a: assert property (bias_power_good_i [*8] |->
        bus_addr_o == (strap_code_i > 3'h4 ? 7'h0d : 7'h08 + strap_code_i)) else $error("bad address");
    role_map_a: assert property (bias_power_good_i [*8] |->
        clock_role_o == (bus_addr_o == 7'h08 ? 2'h0 : bus_addr_o == 7'h0d ? 2'h2 : 2'h1)) else $error("bad role");
    sync_pol_a: assert property (bias_power_good_i [*8] |->
        sync_fall_o == (bus_addr_o == 7'h0a || bus_addr_o == 7'h0c)) else $error("bad sync polarity");
    oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !$past(scl_i))
        else $error("sda moved with scl high");

    // Main scenarios reached
    cover property (wr_strobe_o);
    cover property ($rose(sda_oe_o));
    cover property (reg_ptr_o == 8'h25);
endmodule // i2rt_target_chk

bind i2rt_target i2rt_target_chk u_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .bias_power_good_i(bias_power_good_i), .strap_code_i(strap_code_i),
    .bus_addr_o(bus_addr_o), .clock_role_o(clock_role_o), .sync_fall_o(sync_fall_o), .reg_ptr_o(reg_ptr_o),
    .wr_strobe_o(wr_strobe_o));

`default_nettype wire

// [testbench/i2rt_host.sv]
/*
 * Bus controller model driving SCL and pulling SDA low.
 * Assumes the bench merges SDA with a pull-up.
 */
`default_nettype none

module i2rt_host (
    // Bus pins
    output logic           scl_o,
    output logic           sda_low_o,
    input  wire logic      sda_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // =========================================================
    // Bit level; clock stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic bit_io(input logic b, output logic s);
        sda_low_o = ~b;
        #50 scl_o = 1'b1;
        #50 s = sda_i;
        #50 scl_o = 1'b0;
        #50;
    endtask

    task automatic start;
        sda_low_o = 1'b0;
        #50 scl_o = 1'b1;
        #100 sda_low_o = 1'b1;
        #100 scl_o = 1'b0;
        #50;
    endtask

    task automatic stop;
        sda_low_o = 1'b1;
        #50 scl_o = 1'b1;
        #100 sda_low_o = 1'b0;
        #100;
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(~ack, s);
    endtask

    task automatic bits(input int n);
        logic s;
        repeat (n) bit_io(1'b1, s);
    endtask
endmodule // i2rt_host

`default_nettype wire

// [testbench/i2rt_target_tb.sv]
/*
 * Self-checking bench for the I2C target.
 * Assumes the host model and a register file of value ptr^5a.
 */
`default_nettype none

module i2rt_target_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] DEV = 7'h0a;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic pg = 1'b0;
    logic [2:0] strap = 3'h0;
    wire logic scl, host_low, sda_oe, sda_o, sync_fall, wstb;
    wire logic [6:0] addr;
    wire logic [1:0] role;
    wire logic [7:0] ptr, wdat;
    wire logic sda = ~(host_low | (sda_oe & ~sda_o));
    wire logic [7:0] rdat = ptr ^ 8'h5a;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;

    i2rt_host host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));
    i2rt_target uut (.core_clk_i(core_clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .bias_power_good_i(pg), .strap_code_i(strap), .bus_addr_o(addr),
        .clock_role_o(role), .sync_fall_o(sync_fall), .reg_ptr_o(ptr), .wr_data_o(wdat),
        .wr_strobe_o(wstb), .rd_data_i(rdat));

    // =========================================================
    // Clock, timeout and reporting
    initial forever #12.5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Reset with a strap, then power good
    task automatic pwr(input logic [2:0] c);
        @(posedge core_clk) #1 rst_b = 1'b0;
        pg = 1'b0;
        strap = c;
        repeat (2) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 pg = 1'b1;
        repeat (10) @(posedge core_clk);
        #1;  // Host moves just after the edge, never on it
    endtask

    // =========================================================
    // Scenarios
    task automatic t_nopg;
        logic a;
        host.start();
        host.wbyte({7'h0d, 1'b0}, a);
        chk(a, 0);
        host.stop();
        chk(ptr, 0);
    endtask

    task automatic t_straps;
        for (int k = 0; k < 7; k++) begin
            pwr(k[2:0]);
            chk(addr, k > 4 ? 7'h0d : 7'h08 + k[6:0]);
            chk(role, k == 0 ? 2'h0 : k > 4 ? 2'h2 : 2'h1);
            chk(sync_fall, k == 2 || k == 4);
        end
    endtask

    task automatic t_write;
        logic a;
        host.start();
        host.wbyte({DEV, 1'b0}, a);
        chk(a, 1);
        host.wbyte(8'h10, a);
        #100 chk(ptr, 8'h10);
        for (int i = 0; i < 3; i++) begin
            host.wbyte(8'hc0 + i[7:0], a);
            chk(a, 1);
            #100 chk(wdat, 8'hc0 + i[7:0]);
        end
        host.stop();
        chk(ptr, 8'h13);
    endtask

    task automatic t_read;
        logic a;
        logic [7:0] d;
        host.start();
        host.wbyte({DEV, 1'b0}, a);
        host.wbyte(8'h20, a);
        host.start();
        host.wbyte({DEV, 1'b1}, a);
        chk(a, 1);
        for (int i = 0; i < 3; i++) begin
            host.rbyte(i < 2, d);
            chk(d, (8'h20 + i[7:0]) ^ 8'h5a);
        end
        host.stop();
        host.start();
        host.wbyte({DEV, 1'b1}, a);
        host.rbyte(1'b0, d);
        chk(d, 8'h23 ^ 8'h5a);
        host.stop();
        host.start();
        host.wbyte({DEV, 1'b1}, a);
        host.bits(4);
        #100 chk(ptr, 8'h24);
        host.bits(1);
        #100 chk(ptr, 8'h25);
        host.stop();
        chk(ptr, 8'h25);
    endtask

    task automatic t_other;
        logic a;
        host.start();
        host.wbyte({7'h30, 1'b0}, a);
        chk(a, 0);
        host.wbyte(8'h77, a);
        host.stop();
        chk(ptr, 8'h25);
        chk(wdat, 8'hc2);
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 t_nopg();
        t_straps();
        pwr(3'h2);
        t_write();
        t_read();
        t_other();
        stop_test();
    end
endmodule // i2rt_target_tb

`default_nettype wire
